// ---- src/chc_params.svh ----
// register offsets, reset values and field positions of the completion block
`ifndef CHC_PARAMS_SVH
`define CHC_PARAMS_SVH
`define CHC_OFS_CTRL 8'h00
`define CHC_OFS_STATE 8'h04
`define CHC_OFS_INT_STAT 8'h08
`define CHC_OFS_INT_CLR 8'h0c
`define CHC_OFS_INT_EN 8'h10
`define CHC_OFS_SKIP_CNT 8'h14
`define CHC_CTRL_RST 32'h0000_0001
`define CHC_INT_EN_RST 5'h00
`define CHC_CTRL_ENABLE 0
`define CHC_CTRL_COLOUR 1
`define CHC_EVT_PARITY 0
`define CHC_EVT_DROP 1
`define CHC_EVT_SKIP 2
`define CHC_EVT_WRDONE 3
`define CHC_EVT_RSVD 4
`define CHC_EVT_W 5
`define CHC_KIND_NO_WAIT 2'b00
`define CHC_KIND_DEFERRED 2'b01
`define CHC_KIND_RSVD 2'b10
`define CHC_KIND_HAS_PLD 2'b11
`endif

// ---- src/chc_pkg.sv ----
// types shared by the completion and status block
package chc_pkg;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_SEND = 2'b10
    } chc_state_e;

    // control fields travelling with a completion entry
    typedef struct packed {
        logic [10:0] queue;
        logic marker;
        logic user_trig;
        logic [2:0] port;
        logic [1:0] cmpl_wait_kind;
        logic [15:0] awaited_payload_tag;
        logic [2:0] colour_bit_select;
        logic [2:0] fault_bit_select;
        logic marker_skip_write;
        logic [1:0] cmpl_entry_length;
    } chc_cmpl_ctrl_s;

    // per-descriptor outcome from the engine's payload path
    typedef struct packed {
        logic valid;
        logic [10:0] queue;
        logic drop;
        logic last;
        logic has_cmpt;
        logic fault;
    } chc_desc_evt_s;

    // write completion returned for a payload write request
    typedef struct packed {
        logic valid;
        logic last;
        logic [15:0] tag;
    } chc_wr_cpl_s;
endpackage

// ---- src/chc_cmpl_status.sv ----
// card-to-host completion entry port and status reporting
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "chc_params.svh"

// Function
// (RL1) kind 00: forward entry without waiting
// (RL2) kind 01: hold entry until payload sent
// (RL3) kind 11: send after own payload; 10 reserved
// (RL4) wait for the supplied payload tag
// (RL5) colour index selects colour bit position
// (RL6) error index selects error bit position
// (RL7) suppress input drops marker entries
// (RL8) user holds valid until ready
// (RL9) drop flag: 1 dropped, 0 accepted
// (RL10) completion flag 0 if dropped or none
// (RL11) error flag follows descriptor fault
// (RL12) one pulse per packet on write done
// (RL13) size code 8, 16, 32, 64 bytes
// (RL14) odd parity per 32-bit data slice
// (RL15) status valid one cycle per descriptor
// (RL16) entry taken when valid and ready high
module chc_cmpl_status #(
    parameter int DATA_W = 512,
    parameter int ADDR_W = 8
) (
    input wire logic clock, // 10 MHz block clock
    input wire logic rst_n, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped
    input wire logic cmpl_in_valid, // entry offered
    output logic cmpl_in_ready, // entry accepted
    input wire logic [DATA_W-1:0] cmpl_in_data, // entry body
    input wire logic [DATA_W/32-1:0] cmpl_slice_parity, // odd parity
    input wire chc_pkg::chc_cmpl_ctrl_s cmpl_in_ctrl, // entry controls
    output logic ring_out_valid, // entry to host ring
    input wire logic ring_out_ready, // host ring takes entry
    output logic [DATA_W-1:0] ring_out_data, // entry body out
    output logic [6:0] ring_out_bytes, // entry length in bytes
    output logic [10:0] ring_out_queue, // entry queue
    input wire chc_pkg::chc_desc_evt_s desc_evt, // descriptor outcome
    input wire chc_pkg::chc_wr_cpl_s pay_wr_cpl, // payload write cpl
    output logic card_host_stat_valid, // status strobe
    output logic [10:0] card_host_stat_queue, // status queue
    output logic card_host_stat_discarded, // packet dropped
    output logic card_host_stat_final_desc, // last descriptor
    output logic card_host_stat_has_entry, // packet has completion
    output logic card_host_stat_desc_fault, // descriptor error
    output logic payload_write_done_pulse, // last write completed
    output logic irq // level interrupt
);
    localparam int SLICES = DATA_W / 32;

    // number of 32-bit slices an entry of this size code covers
    function automatic int slices_of(input logic [1:0] len);
        slices_of = 2 << len; // [RL13]
    endfunction

    // odd parity over the slices that belong to the entry
    function automatic logic parity_bad(input logic [DATA_W-1:0] d,
                                        input logic [SLICES-1:0] p,
                                        input logic [1:0] len);
        logic bad;
        bad = 1'b0;
        for (int i = 0; i < SLICES; i++) begin
            if (i < slices_of(len) && !(^{d[i*32 +: 32], p[i]})) begin
                bad = 1'b1; // [RL14]
            end
        end
        parity_bad = bad;
    endfunction

    // clear slices beyond the entry length
    function automatic logic [DATA_W-1:0] mask_len(
            input logic [DATA_W-1:0] d, input logic [1:0] len);
        logic [DATA_W-1:0] m;
        m = d;
        for (int i = 0; i < SLICES; i++) begin
            if (i >= slices_of(len)) begin
                m[i*32 +: 32] = 32'h0000_0000;
            end
        end
        mask_len = m;
    endfunction

    chc_pkg::chc_state_e state_reg, state_next;
    logic [31:0] ctrl_reg;
    logic [`CHC_EVT_W-1:0] int_stat_reg, int_en_reg;
    logic [15:0] skip_cnt_reg;
    logic [15:0] sent_tag_reg;
    logic sent_seen_reg;
    logic [DATA_W-1:0] entry_reg;
    logic [1:0] len_reg;
    logic [10:0] queue_reg;
    logic [15:0] await_reg;
    logic wdone_reg;
    chc_pkg::chc_desc_evt_s stat_reg;

    wire engine_on = ctrl_reg[`CHC_CTRL_ENABLE];
    wire colour_val = ctrl_reg[`CHC_CTRL_COLOUR];
    wire take = cmpl_in_valid && cmpl_in_ready; // [RL16]
    wire [1:0] kind = cmpl_in_ctrl.cmpl_wait_kind;
    // reserved kind is accepted: handled as no-wait, flagged
    wire kind_rsvd = kind == `CHC_KIND_RSVD; // [RL3]
    wire must_wait = kind == `CHC_KIND_DEFERRED ||
                     kind == `CHC_KIND_HAS_PLD; // [RL2] [RL3]
    wire skip_now = cmpl_in_ctrl.marker &&
                    cmpl_in_ctrl.marker_skip_write; // [RL7]
    wire par_bad = parity_bad(cmpl_in_data, cmpl_slice_parity,
                              cmpl_in_ctrl.cmpl_entry_length);
    wire pay_done = pay_wr_cpl.valid && pay_wr_cpl.last;
    // the last tag completed before the entry arrived still counts
    wire tag_hit = (pay_done && pay_wr_cpl.tag == await_reg) ||
                   (sent_seen_reg && sent_tag_reg == await_reg); // [RL4]

    logic [DATA_W-1:0] entry_built;
    always_comb begin
        entry_built = mask_len(cmpl_in_data,
                               cmpl_in_ctrl.cmpl_entry_length);
        // index 0 means no bit; otherwise the index is the bit position
        if (cmpl_in_ctrl.colour_bit_select != 3'h0) begin
            entry_built[cmpl_in_ctrl.colour_bit_select] = colour_val; // [RL5]
        end
        if (cmpl_in_ctrl.fault_bit_select != 3'h0) begin
            entry_built[cmpl_in_ctrl.fault_bit_select] = par_bad; // [RL6]
        end
    end

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            chc_pkg::ST_IDLE: begin
                if (take && !skip_now) begin
                    state_next = must_wait ? chc_pkg::ST_WAIT
                                           : chc_pkg::ST_SEND; // [RL1]
                end
            end
            chc_pkg::ST_WAIT: begin
                if (tag_hit) begin
                    state_next = chc_pkg::ST_SEND; // [RL2] [RL3] [RL4]
                end
            end
            chc_pkg::ST_SEND: begin
                if (ring_out_ready) begin
                    state_next = chc_pkg::ST_IDLE;
                end
            end
            default: state_next = chc_pkg::ST_IDLE;
        endcase
    end

    // one entry in flight; the user holds valid meanwhile [RL8]
    assign cmpl_in_ready = state_reg == chc_pkg::ST_IDLE && engine_on;
    assign ring_out_valid = state_reg == chc_pkg::ST_SEND;
    assign ring_out_data = entry_reg;
    assign ring_out_bytes = 7'((8 << len_reg)); // [RL13]
    assign ring_out_queue = queue_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= chc_pkg::ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            entry_reg <= '0;
            len_reg <= 2'h0;
            queue_reg <= 11'h000;
            await_reg <= 16'h0000;
        end else if (take) begin
            entry_reg <= entry_built;
            len_reg <= cmpl_in_ctrl.cmpl_entry_length;
            queue_reg <= cmpl_in_ctrl.queue;
            await_reg <= cmpl_in_ctrl.awaited_payload_tag;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            sent_tag_reg <= 16'h0000;
            sent_seen_reg <= 1'b0;
        end else if (pay_done) begin
            sent_tag_reg <= pay_wr_cpl.tag;
            sent_seen_reg <= 1'b1;
        end
    end

    // registered so the pulse is one clean cycle per packet
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wdone_reg <= 1'b0;
        end else begin
            wdone_reg <= pay_done; // [RL12]
        end
    end
    assign payload_write_done_pulse = wdone_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            stat_reg <= '0;
        end else begin
            stat_reg <= desc_evt; // [RL15]
        end
    end
    assign card_host_stat_valid = stat_reg.valid; // [RL15]
    assign card_host_stat_queue = stat_reg.queue;
    assign card_host_stat_discarded = stat_reg.drop; // [RL9]
    assign card_host_stat_final_desc = stat_reg.last; // [RL15]
    assign card_host_stat_has_entry = !stat_reg.drop &&
                                      stat_reg.has_cmpt; // [RL10]
    assign card_host_stat_desc_fault = stat_reg.fault; // [RL11]

    // events feeding the sticky status bits
    wire [`CHC_EVT_W-1:0] evt;
    assign evt[`CHC_EVT_PARITY] = take && par_bad;
    assign evt[`CHC_EVT_DROP] = desc_evt.valid && desc_evt.last &&
                                desc_evt.drop;
    assign evt[`CHC_EVT_SKIP] = take && skip_now;
    assign evt[`CHC_EVT_WRDONE] = pay_done;
    assign evt[`CHC_EVT_RSVD] = take && kind_rsvd;

    // apb decode; zero wait states
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire hit_ctrl = paddr == ADDR_W'(`CHC_OFS_CTRL);
    wire hit_state = paddr == ADDR_W'(`CHC_OFS_STATE);
    wire hit_stat = paddr == ADDR_W'(`CHC_OFS_INT_STAT);
    wire hit_clr = paddr == ADDR_W'(`CHC_OFS_INT_CLR);
    wire hit_en = paddr == ADDR_W'(`CHC_OFS_INT_EN);
    wire hit_cnt = paddr == ADDR_W'(`CHC_OFS_SKIP_CNT);
    wire mapped = hit_ctrl || hit_state || hit_stat || hit_clr ||
                  hit_en || hit_cnt;
    wire [`CHC_EVT_W-1:0] clr_mask = (wr && hit_clr) ?
                                     pwdata[`CHC_EVT_W-1:0] : '0;

    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    wire wr_ctrl = wr && hit_ctrl;
    wire wr_en = wr && hit_en;
    // a new event wins over a clear in the same cycle
    wire [`CHC_EVT_W-1:0] int_stat_next = (int_stat_reg & ~clr_mask) | evt;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CHC_CTRL_RST;
        end else if (wr_ctrl) begin
            ctrl_reg <= {30'h0, pwdata[1:0]};
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_en_reg <= `CHC_INT_EN_RST;
        end else if (wr_en) begin
            int_en_reg <= pwdata[`CHC_EVT_W-1:0];
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            int_stat_reg <= '0;
        end else begin
            int_stat_reg <= int_stat_next;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            skip_cnt_reg <= 16'h0000;
        end else if (evt[`CHC_EVT_SKIP]) begin
            skip_cnt_reg <= skip_cnt_reg + 16'h0001; // [RL7]
        end
    end

    assign irq = |(int_stat_reg & int_en_reg);

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_ctrl) begin
            rd_mux = ctrl_reg;
        end else if (hit_state) begin
            rd_mux = {sent_tag_reg, 13'h0, sent_seen_reg,
                      state_reg};
        end else if (hit_stat) begin
            rd_mux = {27'h0, int_stat_reg};
        end else if (hit_en) begin
            rd_mux = {27'h0, int_en_reg};
        end else if (hit_cnt) begin
            rd_mux = {16'h0000, skip_cnt_reg};
        end
    end

    // read data registered; captured in the setup cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_mux;
        end
    end
endmodule

// ---- verification/chc_cmpl_status_assertions.sv ----
// concurrent checks on the completion and status ports
`timescale 1ns/1ps
module chc_cmpl_status_assertions (
    input wire logic clock, // block clock
    input wire logic rst_n, // reset, active low
    input wire logic cmpl_in_valid, // entry offered
    input wire logic cmpl_in_ready, // entry accepted
    input wire chc_pkg::chc_cmpl_ctrl_s cmpl_in_ctrl, // entry controls
    input wire logic ring_out_valid, // entry to ring
    input wire logic [6:0] ring_out_bytes, // entry length
    input wire chc_pkg::chc_desc_evt_s desc_evt, // descriptor outcome
    input wire chc_pkg::chc_wr_cpl_s pay_wr_cpl, // write completion
    input wire logic card_host_stat_valid, // status strobe
    input wire logic [10:0] card_host_stat_queue, // status queue
    input wire logic card_host_stat_discarded, // dropped
    input wire logic card_host_stat_final_desc, // last descriptor
    input wire logic card_host_stat_has_entry, // has completion
    input wire logic card_host_stat_desc_fault, // descriptor error
    input wire logic payload_write_done_pulse // write done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    wire logic take = cmpl_in_valid && cmpl_in_ready;
    wire logic skip = cmpl_in_ctrl.marker && cmpl_in_ctrl.marker_skip_write;
    wire logic plain = take && !skip && cmpl_in_ctrl.cmpl_wait_kind == 2'b00;
    a_plain_forward: assert property (plain |=> ring_out_valid)
        else $error("entry without wait not forwarded");
    a_entry_length: assert property (plain |=>
        ring_out_bytes == (7'h08 << $past(cmpl_in_ctrl.cmpl_entry_length)))
        else $error("entry length wrong");
    a_marker_skip: assert property (take && skip |=> !ring_out_valid)
        else $error("suppressed marker entry reached ring");
    a_one_flight: assert property (take && !skip |=> !cmpl_in_ready)
        else $error("second entry accepted while one held");
    a_stat_strobe: assert property (desc_evt.valid
        ##1 !desc_evt.valid |->
        card_host_stat_valid ##1 !card_host_stat_valid)
        else $error("status strobe not one cycle");
    a_drop_flag: assert property (desc_evt.valid |=>
        card_host_stat_discarded == $past(desc_evt.drop))
        else $error("drop flag wrong");
    a_entry_flag: assert property (desc_evt.valid |=>
        card_host_stat_has_entry ==
        ($past(desc_evt.has_cmpt) && !$past(desc_evt.drop)))
        else $error("completion flag wrong");
    a_fault_flag: assert property (desc_evt.valid |=>
        card_host_stat_desc_fault == $past(desc_evt.fault))
        else $error("error flag wrong");
    a_last_queue: assert property (desc_evt.valid |=>
        card_host_stat_final_desc == $past(desc_evt.last) &&
        card_host_stat_queue == $past(desc_evt.queue))
        else $error("last flag or queue wrong");
    a_done_pulse: assert property (pay_wr_cpl.valid
        && pay_wr_cpl.last |=> payload_write_done_pulse)
        else $error("write done pulse missing");
    a_done_cause: assert property (payload_write_done_pulse |->
        $past(pay_wr_cpl.valid) && $past(pay_wr_cpl.last))
        else $error("write done pulse without cause");
endmodule

// ---- verification/chc_user_model.sv ----
// user-side model that offers completion entries to the engine
`timescale 1ns/1ps
module chc_user_model (
    input wire logic clock, // block clock
    input wire logic rst_n, // reset, active low
    input wire logic go, // offer the entry on ctrl_in
    input wire logic bad_par, // spoil slice 0 parity on command
    input wire chc_pkg::chc_cmpl_ctrl_s ctrl_in, // fields to offer
    input wire logic cmpl_in_ready, // engine takes entry
    output logic cmpl_in_valid, // entry offered
    output logic [511:0] cmpl_in_data, // entry body
    output logic [15:0] cmpl_slice_parity, // odd parity per slice
    output chc_pkg::chc_cmpl_ctrl_s cmpl_in_ctrl // entry controls
);
    localparam logic [31:0] slice_pat = 32'h5a5a_0000;
    logic [15:0] par;
    assign par = {16{~^slice_pat}} ^ {15'h0, bad_par};
    // released lines invert so stale values cannot pass for an entry
    assign cmpl_in_data = cmpl_in_valid ? {16{slice_pat}} : ~{16{slice_pat}};
    assign cmpl_slice_parity = cmpl_in_valid ? par : ~par;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cmpl_in_valid <= 1'b0;
            cmpl_in_ctrl <= '0;
        end else if (go) begin
            // bench never offers kind 2'b10
            cmpl_in_valid <= 1'b1;
            cmpl_in_ctrl <= ctrl_in;
        end else if (cmpl_in_valid && cmpl_in_ready) begin
            cmpl_in_valid <= 1'b0;
            cmpl_in_ctrl <= ~cmpl_in_ctrl;
        end
    end
endmodule

// ---- verification/testbench.sv ----
// self-checking bench for the completion and status block
`timescale 1ns/1ps
`include "chc_params.svh"
module testbench;
    logic clock, rst_n, psel, penable, pwrite, go, bad_par, ring_out_ready;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd, w;
    logic pready, pslverr, err, cmpl_in_valid, cmpl_in_ready, ring_out_valid;
    logic [511:0] cmpl_in_data, ring_out_data;
    logic [15:0] cmpl_slice_parity;
    logic [6:0] ring_out_bytes;
    logic [10:0] sq, rq;
    logic [4:0] k;
    logic sv, sd, sf, sh, se, pulse, irq;
    chc_pkg::chc_cmpl_ctrl_s ctl, cmpl_in_ctrl;
    chc_pkg::chc_desc_evt_s desc_evt;
    chc_pkg::chc_wr_cpl_s pay_wr_cpl;
    int num_errors = 0;
    int n_compared = 0;
    chc_cmpl_status u_chc_cmpl_status (.clock(clock), .rst_n(rst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .cmpl_in_valid(cmpl_in_valid),
        .cmpl_in_ready(cmpl_in_ready), .cmpl_in_data(cmpl_in_data),
        .cmpl_slice_parity(cmpl_slice_parity), .cmpl_in_ctrl(cmpl_in_ctrl),
        .ring_out_valid(ring_out_valid), .ring_out_ready(ring_out_ready),
        .ring_out_data(ring_out_data), .ring_out_bytes(ring_out_bytes),
        .ring_out_queue(rq), .desc_evt(desc_evt), .pay_wr_cpl(pay_wr_cpl),
        .card_host_stat_valid(sv), .card_host_stat_queue(sq),
        .card_host_stat_discarded(sd), .card_host_stat_final_desc(sf),
        .card_host_stat_has_entry(sh), .card_host_stat_desc_fault(se),
        .payload_write_done_pulse(pulse), .irq(irq));
    chc_user_model u_chc_user_model (.clock(clock), .rst_n(rst_n), .go(go),
        .bad_par(bad_par), .ctrl_in(ctl), .cmpl_in_ready(cmpl_in_ready),
        .cmpl_in_valid(cmpl_in_valid), .cmpl_in_data(cmpl_in_data),
        .cmpl_slice_parity(cmpl_slice_parity), .cmpl_in_ctrl(cmpl_in_ctrl));
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    task automatic end_of_test;
        if (num_errors == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic bail;
        num_errors++;
        $display("[FAIL] %0t wait ran out", $time);
        end_of_test;
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %0t word %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) bail;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
    endtask
    task automatic send(input logic [1:0] kind, input logic [15:0] tag,
                        input logic [1:0] len, input logic [2:0] col,
                        input logic [2:0] flt, input logic [1:0] mk);
        int n;
        n = 0;
        ctl <= {11'h005, mk[1], 1'b0, 3'h0, kind, tag, col, flt, mk[0], len};
        go <= 1'b1;
        @(posedge clock);
        go <= 1'b0;
        do begin
            @(posedge clock);
            n++;
        end while (!(cmpl_in_valid === 1'b1 && cmpl_in_ready === 1'b1) &&
                   n < 50);
        if (n >= 50) bail;
    endtask
    task automatic expect_ring(input logic [31:0] word, input logic [6:0] b);
        @(posedge clock);
        chk_bit(ring_out_valid, 1'b1);
        chk_word(ring_out_data[31:0], word);
        chk_word({25'h0, ring_out_bytes}, {25'h0, b});
        chk_word({21'h0, rq}, 32'h0000_0005);
        // top slice only survives in a 64-byte entry
        chk_word(ring_out_data[511:480],
                 (b == 7'h40) ? 32'h5a5a_0000 : 32'h0);
    endtask
    task automatic finish_pld(input logic [15:0] t, input logic lst,
                              input logic exp);
        pay_wr_cpl <= {1'b1, lst, t};
        @(posedge clock);
        pay_wr_cpl <= '0;
        @(posedge clock);
        chk_bit(ring_out_valid, exp);
        chk_bit(pulse, lst);
    endtask
    initial begin
        {rst_n, psel, penable, pwrite, go, bad_par} = 6'h00;
        {paddr, pwdata, ctl, desc_evt, pay_wr_cpl} = '0;
        ring_out_ready = 1'b1;
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        chk_bit(cmpl_in_ready, 1'b1);
        apb(1'b0, `CHC_OFS_CTRL, '0);
        chk_word(rd, 32'h0000_0001);
        apb(1'b0, `CHC_OFS_INT_EN, '0);
        chk_word(rd, 32'h0);
        apb(1'b0, 8'h18, '0);
        chk_bit(err, 1'b1);
        apb(1'b1, `CHC_OFS_CTRL, 32'h0);
        chk_bit(cmpl_in_ready, 1'b0);
        apb(1'b1, `CHC_OFS_CTRL, 32'h0000_0003);
        for (int i = 0; i < 4; i++) begin
            bad_par <= i[0];
            send(2'b00, 16'h0, i[1:0], 3'(2 * i), 3'(7 - i), 2'b00);
            w = 32'h5a5a_0000;
            if (i > 0) w[2*i] = 1'b1;
            w[7-i] = i[0];
            expect_ring(w, 7'h08 << i);
        end
        bad_par <= 1'b0;
        send(2'b00, 16'h0, 2'b00, 3'h0, 3'h0, 2'b11);
        repeat (2) begin
            @(posedge clock);
            chk_bit(ring_out_valid, 1'b0);
        end
        apb(1'b0, `CHC_OFS_SKIP_CNT, '0);
        chk_word(rd, 32'h1);
        send(2'b00, 16'h0, 2'b00, 3'h0, 3'h0, 2'b10);
        expect_ring(32'h5a5a_0000, 7'h08);
        ring_out_ready <= 1'b0;
        send(2'b00, 16'h0, 2'b00, 3'h0, 3'h0, 2'b00);
        expect_ring(32'h5a5a_0000, 7'h08);
        @(posedge clock);
        chk_bit(ring_out_valid, 1'b1);
        chk_bit(cmpl_in_ready, 1'b0);
        ring_out_ready <= 1'b1;
        @(posedge clock);
        send(2'b01, 16'h0021, 2'b00, 3'h0, 3'h0, 2'b00);
        repeat (3) begin
            @(posedge clock);
            chk_bit(ring_out_valid, 1'b0);
        end
        finish_pld(16'h0022, 1'b1, 1'b0);
        finish_pld(16'h0021, 1'b1, 1'b1);
        send(2'b11, 16'h0031, 2'b01, 3'h0, 3'h0, 2'b00);
        finish_pld(16'h0031, 1'b0, 1'b0);
        finish_pld(16'h0031, 1'b1, 1'b1);
        @(posedge clock);
        chk_bit(pulse, 1'b0);
        for (int i = 0; i <= 16; i++) begin
            desc_evt <= (i < 16) ? {1'b1, 11'(i + 16), 4'(i)} : 16'h0;
            @(posedge clock);
            if (i > 0) begin
                k = 5'(i - 1);
                chk_bit(sv, 1'b1);
                chk_word({21'h0, sq}, 32'(k + 16));
                chk_bit(sd, k[3]);
                chk_bit(sf, k[2]);
                chk_bit(sh, k[1] & ~k[3]);
                chk_bit(se, k[0]);
            end
        end
        @(posedge clock);
        chk_bit(sv, 1'b0);
        apb(1'b0, `CHC_OFS_INT_STAT, '0);
        chk_bit(rd[1], 1'b1);
        apb(1'b1, `CHC_OFS_INT_EN, 32'h2);
        @(posedge clock);
        chk_bit(irq, 1'b1);
        apb(1'b1, `CHC_OFS_INT_EN, 32'h0);
        @(posedge clock);
        chk_bit(irq, 1'b0);
        apb(1'b1, `CHC_OFS_INT_EN, 32'h2);
        apb(1'b1, `CHC_OFS_INT_CLR, 32'h2);
        @(posedge clock);
        chk_bit(irq, 1'b0);
        apb(1'b0, `CHC_OFS_INT_STAT, '0);
        chk_bit(rd[1], 1'b0);
        end_of_test;
    end
endmodule
bind chc_cmpl_status chc_cmpl_status_assertions u_chk (.clock(clock),
    .rst_n(rst_n), .cmpl_in_valid(cmpl_in_valid),
    .cmpl_in_ready(cmpl_in_ready), .cmpl_in_ctrl(cmpl_in_ctrl),
    .ring_out_valid(ring_out_valid), .ring_out_bytes(ring_out_bytes),
    .desc_evt(desc_evt), .pay_wr_cpl(pay_wr_cpl),
    .card_host_stat_valid(card_host_stat_valid),
    .card_host_stat_queue(card_host_stat_queue),
    .card_host_stat_discarded(card_host_stat_discarded),
    .card_host_stat_final_desc(card_host_stat_final_desc),
    .card_host_stat_has_entry(card_host_stat_has_entry),
    .card_host_stat_desc_fault(card_host_stat_desc_fault),
    .payload_write_done_pulse(payload_write_done_pulse));
